// ===== mmf_fault_status.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - An access violation while unstacking on exception return sets bit 3, else it reads 0.
// - An unstacking violation is chained to the handler, the return frame stays in place.
// - After an unstacking violation the stack pointer is not moved, no save; no address write unless a data violation comes in the same cycle.
// - A load or store to a location that forbids it sets bit 1.
// - A data violation makes the stacked PC the faulting one and captures the access address.
// - An instruction fetch from a location that forbids execution sets bit 0.
// - Any fetch from an execute-never region faults, whatever the protection unit state.
// - An instruction violation stacks the faulting PC but captures no fault address.
// - Each violation flag stays set until software writes 1 to it; writing 0 keeps it.
// - Bit 2 is reserved and reads zero; software preserves it.
// - Bit 7 is set when a data violation captures an address; writing 1 clears it, the address is kept.
module mmf_fault_status (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire mmf_pkg::mmf_viol_t viol_in,
  input wire mmf_pkg::mmf_fetch_t fetch_in,
  output logic [31:0] fault_addr_out,
  output mmf_pkg::mmf_act_t act_out,
  output logic irq_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================
  // Declarations
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q, fault_addr_q, mask_q;
  logic [3:0] wstrb_q;
  logic irq_q, rd_stat_q;
  mmf_pkg::mmf_act_t act_q, act_d;
  logic aw_take, w_take, wr_do, ar_take;
  logic wr_status, wr_mask, wr_mapped, rd_mapped;
  logic fetch_viol, any_viol;
  logic [7:0] stat_clr;
  logic flag_unstk, flag_data, flag_instr, flag_avalid;
  logic [2:0] irq_evt, irq_bits, irq_mask3;
  logic istat_rd_clr;
  logic [31:0] stat_word, istat_word, rd_word;

  // ==========================================
  // Event decode
  // Execute-never faults regardless of protection unit state
  assign fetch_viol = fetch_in.valid & (fetch_in.xn | (fetch_in.mpu_en & fetch_in.mpu_deny));
  assign any_viol = viol_in.unstack | viol_in.data | fetch_viol;

  // Exception sequencer directions for the next cycle
  assign act_d.handler_entry = any_viol;
  assign act_d.context_save = (viol_in.data | fetch_viol) & ~viol_in.unstack;
  assign act_d.sp_adjust = (viol_in.data | fetch_viol) & ~viol_in.unstack;
  assign act_d.pc_faulting = viol_in.data | fetch_viol;
  assign act_d.addr_capture = viol_in.data;

  // ==========================================
  // Write channel handshake and decode
  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take = s_axi_wvalid & wready_q;
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;
  assign aw_have_d = wr_do ? 1'b0 : (aw_have_q | aw_take);
  assign w_have_d = wr_do ? 1'b0 : (w_have_q | w_take);
  assign bvalid_d = wr_do | (bvalid_q & ~s_axi_bready);
  assign awready_d = ~aw_have_d & ~bvalid_d;
  assign wready_d = ~w_have_d & ~bvalid_d;
  assign wr_status = wr_do & (waddr_q == mmf_pkg::OFF_STATUS);
  assign wr_mask = wr_do & (waddr_q == mmf_pkg::OFF_IMASK);
  assign wr_mapped = (waddr_q == mmf_pkg::OFF_STATUS) | (waddr_q == mmf_pkg::OFF_FADDR) |
                     (waddr_q == mmf_pkg::OFF_ISTAT) | (waddr_q == mmf_pkg::OFF_IMASK);
  assign bresp_d = wr_do ? (wr_mapped ? mmf_pkg::RESP_OKAY : mmf_pkg::RESP_SLVERR) : bresp_q;

  // Write-one-to-clear vector, only byte lane 0 carries flags
  assign stat_clr = (wr_status & wstrb_q[0]) ? wdata_q[7:0] : 8'h00;

  // Write channel registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= mmf_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // Captured write address and data
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      waddr_q <= 8'h00;
      wdata_q <= mmf_pkg::RST_WORD;
      wstrb_q <= 4'h0;
    end else begin
      waddr_q <= aw_take ? s_axi_awaddr : waddr_q;
      wdata_q <= w_take ? s_axi_wdata : wdata_q;
      wstrb_q <= w_take ? s_axi_wstrb : wstrb_q;
    end
  end

  // Interrupt mask, byte lane 0
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask_q <= mmf_pkg::RST_WORD;
    end else if (wr_mask & wstrb_q[0]) begin
      mask_q <= {24'h000000, wdata_q[7:0]};
    end
  end

  // ==========================================
  // Status flags
  mmf_sticky_bit u_unstk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(viol_in.unstack),
    .clr_in(stat_clr[mmf_pkg::BIT_UNSTK]),
    .q_out(flag_unstk)
  );
  mmf_sticky_bit u_data (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(viol_in.data),
    .clr_in(stat_clr[mmf_pkg::BIT_DATA]),
    .q_out(flag_data)
  );
  mmf_sticky_bit u_instr (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(fetch_viol),
    .clr_in(stat_clr[mmf_pkg::BIT_INSTR]),
    .q_out(flag_instr)
  );
  mmf_sticky_bit u_avalid (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(viol_in.data),
    .clr_in(stat_clr[mmf_pkg::BIT_AVALID]),
    .q_out(flag_avalid)
  );

  // Fault address, written only by a data violation
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_addr_q <= mmf_pkg::RST_FADDR;
    end else if (viol_in.data) begin
      fault_addr_q <= viol_in.data_addr;
    end
  end

  // ==========================================
  // Interrupt status, cleared by reading it
  assign irq_evt = {viol_in.unstack, viol_in.data, fetch_viol};
  assign irq_mask3 = {mask_q[mmf_pkg::BIT_UNSTK], mask_q[mmf_pkg::BIT_DATA],
                      mask_q[mmf_pkg::BIT_INSTR]};
  assign istat_rd_clr = ar_take & (s_axi_araddr == mmf_pkg::OFF_ISTAT);
  for (genvar gi = 0; gi < 3; gi++) begin : g_irq
    mmf_sticky_bit u_ibit (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .set_in(irq_evt[gi]),
      .clr_in(istat_rd_clr),
      .q_out(irq_bits[gi])
    );
  end

  // ==========================================
  // Read words, reserved bits zero
  assign stat_word = {24'h000000, flag_avalid, 3'h0, flag_unstk, 1'b0,
                      flag_data, flag_instr};
  assign istat_word = {28'h0000000, irq_bits[2], 1'b0, irq_bits[1], irq_bits[0]};
  assign rd_mapped = (s_axi_araddr == mmf_pkg::OFF_STATUS) |
                     (s_axi_araddr == mmf_pkg::OFF_FADDR) |
                     (s_axi_araddr == mmf_pkg::OFF_ISTAT) |
                     (s_axi_araddr == mmf_pkg::OFF_IMASK);
  assign rd_word = (s_axi_araddr == mmf_pkg::OFF_STATUS) ? stat_word :
                   (s_axi_araddr == mmf_pkg::OFF_FADDR) ? fault_addr_q :
                   (s_axi_araddr == mmf_pkg::OFF_ISTAT) ? istat_word :
                   (s_axi_araddr == mmf_pkg::OFF_IMASK) ? mask_q : mmf_pkg::RST_WORD;

  // Read channel handshake
  assign ar_take = s_axi_arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  assign arready_d = ~rvalid_d;

  // Read channel registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= mmf_pkg::RST_WORD;
      rresp_q <= mmf_pkg::RESP_OKAY;
      rd_stat_q <= 1'b0;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= ar_take ? rd_word : rdata_q;
      rresp_q <= ar_take ? (rd_mapped ? mmf_pkg::RESP_OKAY : mmf_pkg::RESP_SLVERR) : rresp_q;
      rd_stat_q <= ar_take ? (s_axi_araddr == mmf_pkg::OFF_STATUS) : rd_stat_q;
    end
  end

  // ==========================================
  // Sequencer pulses and interrupt level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      act_q <= '0;
      irq_q <= 1'b0;
    end else begin
      act_q <= act_d;
      irq_q <= |(irq_bits & irq_mask3);
    end
  end

  // Outputs
  assign fault_addr_out = fault_addr_q;
  assign act_out = act_q;
  assign irq_out = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_unstack_sets: assert property (viol_in.unstack |=> flag_unstk)
    else $error("unstack violation did not set bit 3");
  a_data_sets: assert property (viol_in.data |=> flag_data)
    else $error("data violation did not set bit 1");
  a_xn_fetch: assert property (fetch_in.valid & fetch_in.xn |=> flag_instr)
    else $error("execute-never fetch did not set bit 0");
  a_deny_fetch: assert property (fetch_in.valid & fetch_in.mpu_en & fetch_in.mpu_deny
    |=> flag_instr)
    else $error("denied fetch did not set bit 0");
  a_flag_hold: assert property (flag_data & ~stat_clr[mmf_pkg::BIT_DATA]
    |=> flag_data)
    else $error("data flag dropped without a write of one");
  a_set_wins: assert property (viol_in.unstack & stat_clr[mmf_pkg::BIT_UNSTK]
    |=> flag_unstk)
    else $error("clearing write beat a new event");
  a_resv_zero: assert property (rvalid_q & rd_stat_q |-> s_axi_rdata[6:4] == 3'h0
    && s_axi_rdata[2] == 1'b0)
    else $error("reserved status bits read nonzero");
  a_addr_capture: assert property (viol_in.data |=> fault_addr_out == $past(viol_in.data_addr)
    && flag_avalid ##0 act_out.addr_capture && act_out.pc_faulting)
    else $error("data violation address not captured");
  a_avalid_addr: assert property ($rose(flag_avalid) |-> $changed(fault_addr_out)
    || $past(viol_in.data))
    else $error("address valid without a capture");
  a_instr_noaddr: assert property (fetch_viol & ~viol_in.data |=> $stable(fault_addr_out)
    && act_out.pc_faulting && !act_out.addr_capture)
    else $error("instruction violation wrote the fault address");
  a_unstack_chain: assert property (viol_in.unstack & ~viol_in.data & ~fetch_viol
    |=> act_out.handler_entry && !act_out.context_save && !act_out.sp_adjust
    && $stable(fault_addr_out))
    else $error("unstack fault saved context or moved the stack");
  a_irq_level: assert property (|(irq_bits & irq_mask3) |=> irq_out)
    else $error("interrupt not raised for unmasked status");
  a_write_resp: assert property (wr_do |=> s_axi_bvalid)
    else $error("write response missing");

  c_unstack: cover property (viol_in.unstack ##1 flag_unstk);
  c_data_clear: cover property (flag_data ##1 stat_clr[mmf_pkg::BIT_DATA] ##1 !flag_data);
  c_set_wins: cover property (viol_in.data & stat_clr[mmf_pkg::BIT_DATA]);
  c_irq: cover property ($rose(irq_out));

endmodule
`default_nettype wire

// ===== mmf_pkg.sv
// ==========================================
// Memory-management fault status, shared definitions
package mmf_pkg;

  // ==========================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_FADDR = 8'h04;
  localparam logic [7:0] OFF_ISTAT = 8'h08;
  localparam logic [7:0] OFF_IMASK = 8'h0C;

  // ==========================================
  // Field positions in the status, irq status and irq mask words
  localparam int BIT_INSTR = 0;
  localparam int BIT_DATA = 1;
  localparam int BIT_RSVD = 2;
  localparam int BIT_UNSTK = 3;
  localparam int BIT_AVALID = 7;

  // ==========================================
  // Reset values
  localparam logic RST_FLAG = 1'h0;
  localparam logic [31:0] RST_FADDR = 32'h0000_0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // Violation reports from the access-checking logic
  typedef struct packed {
    logic unstack;
    logic data;
    logic [31:0] data_addr;
  } mmf_viol_t;

  // Instruction fetch attributes
  typedef struct packed {
    logic valid;
    logic xn;
    logic mpu_en;
    logic mpu_deny;
  } mmf_fetch_t;

  // Directions to the exception sequencer, one-cycle pulses
  typedef struct packed {
    logic handler_entry;
    logic context_save;
    logic sp_adjust;
    logic pc_faulting;
    logic addr_capture;
  } mmf_act_t;

endpackage

// ===== mmf_sticky_bit.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sticky flag: set has priority over clear
module mmf_sticky_bit (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic q_out
);
  logic flag_q;
  logic flag_d;

  // Next value, an event in the clearing cycle survives
  assign flag_d = set_in | (flag_q & ~clr_in);

  // Flag storage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_q <= mmf_pkg::RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q_out = flag_q;
endmodule
`default_nettype wire

// ===== mmf_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================
  // Clock, reset and design stimulus
  logic clk = 1'h0;
  logic rst = 1'h1;
  mmf_pkg::mmf_viol_t viol = '0;
  mmf_pkg::mmf_fetch_t fetch = '0;
  mmf_pkg::mmf_act_t act;
  logic [31:0] faddr;
  logic irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs;
  int err_count = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  mmf_fault_status mmf_fault_status_inst (
    .clk_in(clk), .sys_rst_in(rst), .viol_in(viol), .fetch_in(fetch),
    .fault_addr_out(faddr), .act_out(act), .irq_out(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ==========================================
  // Shared helpers
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Final verdict
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each dropped on its own take
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  // Bus read: hold the request until taken, then wait for the answer
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // One-cycle event, then the action pulse and its end
  task automatic pulse(input logic u, input logic dv, input logic [31:0] a,
                       input mmf_pkg::mmf_fetch_t f, input logic [4:0] exp_act);
    @(posedge clk);
    viol <= '{unstack: u, data: dv, data_addr: a};
    fetch <= f;
    @(posedge clk);
    viol <= '0;
    fetch <= '0;
    #1 chk({27'h0, act}, {27'h0, exp_act});
    @(posedge clk);
    #1 chk({27'h0, act}, 32'h0000_0000);
  endtask

  // ==========================================
  // Scenarios
  // Reset values and the unmapped place
  task automatic t_reset();
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, mmf_pkg::RST_WORD);
    axi_rd(mmf_pkg::OFF_FADDR, rd, rs);
    chk(rd, mmf_pkg::RST_FADDR);
    axi_rd(8'h10, rd, rs);
    chk({30'h0, rs}, {30'h0, mmf_pkg::RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    axi_wr(8'h10, 32'hFFFF_FFFF, rs);
    chk({30'h0, rs}, {30'h0, mmf_pkg::RESP_SLVERR});
  endtask

  // Data violation: flag, address capture, write-zero keeps, write-one clears
  task automatic t_data();
    pulse(1'h0, 1'h1, 32'hA5A5_1234, '0, 5'h1F);
    chk(faddr, 32'hA5A5_1234);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0082);
    axi_rd(mmf_pkg::OFF_FADDR, rd, rs);
    chk(rd, 32'hA5A5_1234);
    chk({30'h0, rs}, {30'h0, mmf_pkg::RESP_OKAY});
    // Zeros in the flag lane, reserved bit written back as read
    axi_wr(mmf_pkg::OFF_STATUS, 32'hFFFF_FF00, rs);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0082);
    axi_wr(mmf_pkg::OFF_STATUS, 32'h0000_0082, rs);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0000);
  endtask

  // Fetch violations with and without the protection unit
  task automatic t_instr();
    pulse(1'h0, 1'h0, 32'h0, '{valid: 1'h1, xn: 1'h1, mpu_en: 1'h0, mpu_deny: 1'h0},
          5'h1E);
    pulse(1'h0, 1'h0, 32'h0, '{valid: 1'h1, xn: 1'h0, mpu_en: 1'h1, mpu_deny: 1'h1},
          5'h1E);
    pulse(1'h0, 1'h0, 32'h0, '{valid: 1'h1, xn: 1'h0, mpu_en: 1'h0, mpu_deny: 1'h1},
          5'h00);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0001);
    axi_rd(mmf_pkg::OFF_FADDR, rd, rs);
    chk(rd, 32'hA5A5_1234);
    chk(faddr, 32'hA5A5_1234);
  endtask

  // Unstacking violation: handler entry only, no save, no address
  task automatic t_unstack();
    pulse(1'h1, 1'h0, 32'h0000_5555, '0, 5'h10);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0009);
    axi_rd(mmf_pkg::OFF_FADDR, rd, rs);
    chk(rd, 32'hA5A5_1234);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_wr(mmf_pkg::OFF_STATUS, 32'h0000_0009, rs);
  endtask

  // A clearing write whose cycle of effect meets a new data event
  task automatic t_collide();
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    pulse(1'h0, 1'h1, 32'h0000_0BAD, '0, 5'h1F);
    @(posedge clk);
    awaddr <= mmf_pkg::OFF_STATUS;
    awvalid <= 1'h1;
    wdata <= 32'h0000_0082;
    wstrb <= 4'hF;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    // The write acts one edge after both takes, the event meets it there
    viol <= '{unstack: 1'h0, data: 1'h1, data_addr: 32'h0000_0C0D};
    @(posedge clk);
    viol <= '0;
    do @(posedge clk); while (bvalid !== 1'h1);
    chk({30'h0, bresp}, {30'h0, mmf_pkg::RESP_OKAY});
    bready <= 1'h0;
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0082);
    chk(faddr, 32'h0000_0C0D);
    axi_wr(mmf_pkg::OFF_STATUS, 32'h0000_0082, rs);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, 32'h0000_0000);
  endtask

  // Interrupt status, mask and clear-on-read
  task automatic t_irq();
    axi_rd(mmf_pkg::OFF_ISTAT, rd, rs);
    chk(rd, 32'h0000_000B);
    axi_rd(mmf_pkg::OFF_ISTAT, rd, rs);
    chk(rd, 32'h0000_0000);
    axi_wr(mmf_pkg::OFF_IMASK, 32'h0000_0002, rs);
    chk({30'h0, rs}, {30'h0, mmf_pkg::RESP_OKAY});
    axi_rd(mmf_pkg::OFF_IMASK, rd, rs);
    chk(rd, 32'h0000_0002);
    pulse(1'h0, 1'h0, 32'h0, '{valid: 1'h1, xn: 1'h1, mpu_en: 1'h0, mpu_deny: 1'h0},
          5'h1E);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    pulse(1'h0, 1'h1, 32'h0000_00C0, '0, 5'h1F);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_rd(mmf_pkg::OFF_ISTAT, rd, rs);
    chk(rd, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // Reset in mid-run returns flags, address, mask and interrupt to rest
  task automatic t_rerst();
    pulse(1'h0, 1'h1, 32'h0000_7777, '0, 5'h1F);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1 chk({31'h0, irq}, 32'h0000_0000);
    chk(faddr, mmf_pkg::RST_FADDR);
    axi_rd(mmf_pkg::OFF_STATUS, rd, rs);
    chk(rd, mmf_pkg::RST_WORD);
    axi_rd(mmf_pkg::OFF_IMASK, rd, rs);
    chk(rd, mmf_pkg::RST_WORD);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_data();
    t_instr();
    t_unstack();
    t_collide();
    t_irq();
    t_rerst();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
